/* File: prs_sequencer.sv */
// Power-up reset sequencer with Avalon-MM status registers
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
module prs_sequencer #(
    parameter logic [15:0] POWERUP_TIMER_TICKS = prs_pkg::POWERUP_TIMER_TICKS[15:0]
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_on_pulse,
    input wire logic brownout_below,
    input wire logic master_clear_pin_n,
    input wire logic rc_tick,
    input wire logic osc_tick,
    input wire logic sleep_wake,
    input wire logic brownout_enable_cfg,
    input wire logic powerup_timer_enable_n,
    input wire logic [1:0] osc_mode,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic chip_reset,
    output logic clock_hold,
    output logic irq
);
    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire logic rst_i_n = rst_sync_q;

    function automatic logic is_crystal(input logic [1:0] mode);
        is_crystal = (mode != prs_pkg::OSC_RESISTOR_CAPACITOR);
    endfunction : is_crystal

    // Counters
    prs_cnt_if powerup_timer_if ();
    prs_cnt_if ost_if ();

    prs_tick_counter u_powerup_timer (
        .clock(clock),
        .rst_n(rst_i_n),
        .cif(powerup_timer_if)
    );

    prs_tick_counter u_ost (
        .clock(clock),
        .rst_n(rst_i_n),
        .cif(ost_if)
    );

    // Brown-out filter
    wire logic bo_trip;
    prs_bo_filter u_bo (
        .clock(clock),
        .rst_n(rst_i_n),
        .enable(brownout_enable_cfg),
        .below(brownout_below),
        .trip(bo_trip)
    );

    // Sequencer
    prs_pkg::prs_state_t state_q;
    prs_pkg::prs_state_t state_d;
    logic after_por_q;
    logic after_por_d;

    wire logic powerup_timer_on = !powerup_timer_enable_n || brownout_enable_cfg;
    wire logic crystal = is_crystal(osc_mode);
    wire logic powerup_timer_start;
    wire logic ost_start;
    wire logic released;

    always_comb begin
        state_d = state_q;
        after_por_d = after_por_q;
        if (power_on_pulse) begin
            state_d = prs_pkg::ST_POWER_ON;
            after_por_d = 1'b1;
        end else if (bo_trip) begin
            state_d = prs_pkg::ST_BROWNOUT;
            after_por_d = 1'b0;
        end else begin
            case (state_q)
                prs_pkg::ST_POWER_ON: begin
                    if (powerup_timer_on) begin
                        state_d = prs_pkg::ST_POWERUP_TIMER;
                    end else if (crystal) begin
                        state_d = prs_pkg::ST_OSC_STARTUP;
                    end else begin
                        state_d = prs_pkg::ST_RUN;
                    end
                end
                prs_pkg::ST_BROWNOUT: begin
                    if (!brownout_below) begin
                        state_d = prs_pkg::ST_POWERUP_TIMER;
                    end
                end
                prs_pkg::ST_POWERUP_TIMER: begin
                    if (powerup_timer_if.done) begin
                        if (crystal && after_por_q) begin
                            state_d = prs_pkg::ST_OSC_STARTUP;
                        end else begin
                            state_d = prs_pkg::ST_RUN;
                        end
                    end
                end
                prs_pkg::ST_OSC_STARTUP: begin
                    if (ost_if.done) begin
                        state_d = prs_pkg::ST_RUN;
                    end
                end
                prs_pkg::ST_RUN: begin
                    if (sleep_wake && crystal) begin
                        state_d = prs_pkg::ST_WAKE_STARTUP;
                    end
                end
                prs_pkg::ST_WAKE_STARTUP: begin
                    if (ost_if.done) begin
                        state_d = prs_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_d = prs_pkg::ST_POWER_ON;
                end
            endcase
        end
    end

    // Counter start and release pulses on state entry
    assign powerup_timer_start = (state_d == prs_pkg::ST_POWERUP_TIMER)
        && ((state_q != prs_pkg::ST_POWERUP_TIMER) || power_on_pulse || bo_trip);
    assign ost_start = ((state_d == prs_pkg::ST_OSC_STARTUP) && (state_q != prs_pkg::ST_OSC_STARTUP))
        || ((state_d == prs_pkg::ST_WAKE_STARTUP) && (state_q != prs_pkg::ST_WAKE_STARTUP));
    assign released = (state_d == prs_pkg::ST_RUN) && (state_q != prs_pkg::ST_RUN);

    assign powerup_timer_if.start = powerup_timer_start;
    assign powerup_timer_if.tick = rc_tick;
    assign powerup_timer_if.limit = POWERUP_TIMER_TICKS;
    assign ost_if.start = ost_start;
    assign ost_if.tick = osc_tick;
    assign ost_if.limit = prs_pkg::OST_CYCLES[15:0];

    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            state_q <= prs_pkg::ST_POWER_ON;
            after_por_q <= 1'b1;
        end else begin
            state_q <= state_d;
            after_por_q <= after_por_d;
        end
    end

    // Reset and clock hold outputs
    wire logic in_seq = (state_d != prs_pkg::ST_RUN) && (state_d != prs_pkg::ST_WAKE_STARTUP);
    logic chip_reset_q;
    logic clock_hold_q;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            chip_reset_q <= 1'b1;
            clock_hold_q <= 1'b0;
        end else begin
            // Master clear acts alone once time-outs are over
            chip_reset_q <= in_seq || !master_clear_pin_n;
            clock_hold_q <= (state_d == prs_pkg::ST_WAKE_STARTUP);
        end
    end
    assign chip_reset = chip_reset_q;
    assign clock_hold = clock_hold_q;

    // Bus decode
    wire logic req = avs_read || avs_write;
    logic waitrequest_q;
    wire logic access = req && !waitrequest_q;
    wire logic wr_en = avs_write && access && avs_byteenable[0];
    wire logic sel_power = (avs_address == prs_pkg::OFS_POWER_STATUS);
    wire logic sel_state = (avs_address == prs_pkg::OFS_SEQ_STATE);
    wire logic sel_ist = (avs_address == prs_pkg::OFS_IRQ_STATUS);
    wire logic sel_iclr = (avs_address == prs_pkg::OFS_IRQ_CLEAR);
    wire logic sel_ien = (avs_address == prs_pkg::OFS_IRQ_ENABLE);

    // Power status flags
    logic [1:0] power_q;
    logic [1:0] power_d;
    always_comb begin
        power_d = power_q;
        if (wr_en && sel_power) begin
            power_d = avs_writedata[1:0];
        end
        // Hardware clear wins over a software write
        if (power_on_pulse) begin
            power_d[prs_pkg::BIT_POR_FLAG] = 1'b0;
        end
        if (bo_trip) begin
            power_d[prs_pkg::BIT_BOR_FLAG] = 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            power_q <= prs_pkg::POWER_STATUS_RST;
        end else begin
            power_q <= power_d;
        end
    end

    // Interrupt status, clear and enable
    logic [2:0] ist_q;
    logic [2:0] ist_d;
    logic [2:0] ien_q;
    logic irq_q;
    wire logic [2:0] ev = {released, bo_trip, power_on_pulse};
    wire logic [2:0] clr = (wr_en && sel_iclr) ? avs_writedata[2:0] : 3'h0;
    assign ist_d = (ist_q & ~clr) | ev;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ist_q <= 3'h0;
            ien_q <= prs_pkg::IRQ_EN_RST;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            if (wr_en && sel_ien) begin
                ien_q <= avs_writedata[2:0];
            end
            irq_q <= |(ist_d & ien_q);
        end
    end
    assign irq = irq_q;

    // Read data and one wait state
    wire logic [31:0] rd_mux =
        sel_power ? {30'h0, power_q} :
        sel_state ? {24'h0, chip_reset_q, clock_hold_q, powerup_timer_if.busy, ost_if.busy,
                     after_por_q, 3'(state_q)} :
        sel_ist ? {29'h0, ist_q} :
        sel_ien ? {29'h0, ien_q} :
        32'h0000_0000;
    logic [31:0] readdata_q;
    always_ff @(posedge clock or negedge rst_i_n) begin
        if (!rst_i_n) begin
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            waitrequest_q <= !(req && waitrequest_q);
            if (avs_read && waitrequest_q) begin
                readdata_q <= rd_mux;
            end
        end
    end
    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitrequest_q;
endmodule : prs_sequencer

/* File: prs_pkg.sv */
// Constants and types shared by the power-up reset sequencer
package prs_pkg;
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int BO_FILTER_TIME_US = 100;
    localparam int BO_FILTER_CYCLES = BO_FILTER_TIME_US * CLK_MHZ;
    localparam int BO_CNT_W = 12;
    localparam int POWERUP_TIMER_TIME_US = 72000;
    localparam int RC_TICK_PERIOD_US = 1000;
    localparam int POWERUP_TIMER_TICKS = POWERUP_TIMER_TIME_US / RC_TICK_PERIOD_US;
    localparam int OST_CYCLES = 1024;
    localparam int CNT_W = 16;

    // Register byte offsets
    localparam logic [4:0] OFS_POWER_STATUS = 5'h00;
    localparam logic [4:0] OFS_SEQ_STATE = 5'h04;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
    localparam logic [4:0] OFS_IRQ_CLEAR = 5'h0C;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h10;

    // Power status fields
    localparam int BIT_BOR_FLAG = 0;
    localparam int BIT_POR_FLAG = 1;
    localparam logic [1:0] POWER_STATUS_RST = 2'h0;

    // Interrupt fields
    localparam int IRQ_W = 3;
    localparam int IRQ_POR = 0;
    localparam int IRQ_BROWNOUT = 1;
    localparam int IRQ_RELEASE = 2;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;

    // Oscillator modes
    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL,
        OSC_CRYSTAL_MEDIUM,
        OSC_HIGH_SPEED_CRYSTAL,
        OSC_RESISTOR_CAPACITOR
    } prs_osc_mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_POWER_ON,
        ST_BROWNOUT,
        ST_POWERUP_TIMER,
        ST_OSC_STARTUP,
        ST_RUN,
        ST_WAKE_STARTUP
    } prs_state_t;
endpackage : prs_pkg

/* File: prs_cnt_if.sv */
// Control and status of one tick counter
interface prs_cnt_if;
    logic start;
    logic tick;
    logic [prs_pkg::CNT_W-1:0] limit;
    logic busy;
    logic done;
    modport ctl (output start, output tick, output limit, input busy, input done);
    modport cnt (input start, input tick, input limit, output busy, output done);
endinterface : prs_cnt_if

/* File: prs_tick_counter.sv */
// Counts ticks up to a limit after a start pulse
module prs_tick_counter (
    input wire logic clock,
    input wire logic rst_n,
    prs_cnt_if.cnt cif
);
    logic [prs_pkg::CNT_W-1:0] count_q;
    logic busy_q;
    logic done_q;
    wire logic last_tick = busy_q && cif.tick && (count_q == cif.limit - 16'h0001);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (cif.start) begin
                // Restart wins over a running count
                count_q <= 16'h0000;
                busy_q <= 1'b1;
            end else if (last_tick) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else if (busy_q && cif.tick) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    assign cif.busy = busy_q;
    assign cif.done = done_q;
endmodule : prs_tick_counter

/* File: prs_bo_filter.sv */
// Rejects brown-out dips shorter than the filter time
module prs_bo_filter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic below,
    output logic trip
);
    logic [prs_pkg::BO_CNT_W-1:0] cnt_q;
    logic trip_q;
    localparam logic [prs_pkg::BO_CNT_W-1:0] LIMIT = prs_pkg::BO_FILTER_CYCLES[prs_pkg::BO_CNT_W-1:0];
    wire logic low_long = enable && below && (cnt_q == LIMIT);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 12'h000;
            trip_q <= 1'b0;
        end else begin
            if (!(enable && below)) begin
                cnt_q <= 12'h000;
            end else if (cnt_q != LIMIT) begin
                cnt_q <= cnt_q + 12'h001;
            end
            trip_q <= low_long;
        end
    end

    assign trip = trip_q;
endmodule : prs_bo_filter

/* File: prs_sup_model.sv */
// Behavioural model of the RC and main oscillators that feed the sequencer
module prs_sup_model #(
    parameter int RC_DIV = 8
) (
    input wire logic clock,
    output logic rc_tick,
    output logic osc_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    int rc_cnt = 0;
    initial begin
        rc_tick = 1'b0;
        osc_tick = 1'b0;
    end
    // Both oscillators run free once powered
    always @(posedge clock) begin
        rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
        rc_tick <= (rc_cnt == RC_DIV - 1);
        osc_tick <= !osc_tick;
    end
endmodule : prs_sup_model

/* File: prs_sequencer_checker.sv */
// Concurrent checks on the sequencer's ports
module prs_sequencer_checker #(
    parameter logic [15:0] POWERUP_TIMER_TICKS = 16'h0048
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic power_on_pulse,
    input wire logic brownout_below,
    input wire logic master_clear_pin_n,
    input wire logic brownout_enable_cfg,
    input wire logic [1:0] osc_mode,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic chip_reset,
    input wire logic clock_hold
);
    logic [12:0] below_cnt_q;
    // Consecutive cycles of an enabled brown-out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            below_cnt_q <= 13'h0000;
        end else if (!(brownout_below && brownout_enable_cfg)) begin
            below_cnt_q <= 13'h0000;
        end else if (below_cnt_q != 13'h1FFF) begin
            below_cnt_q <= below_cnt_q + 13'h0001;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_pin_low;
        !master_clear_pin_n [*2];
    endsequence
    por_reset_a: assert property (power_on_pulse |=> chip_reset)
        else $error("chip reset not raised by power-on");
    pin_hold_a: assert property (s_pin_low |-> chip_reset)
        else $error("chip reset low while master clear held");
    pin_release_a: assert property ($fell(chip_reset) |-> $past(master_clear_pin_n))
        else $error("reset released with master clear low");
    bo_hold_a: assert property (below_cnt_q > 13'hFA4 |-> chip_reset)
        else $error("long brown-out did not hold reset");
    rc_nohold_a: assert property ($rose(clock_hold) |-> osc_mode != 2'h3)
        else $error("start-up count in RC mode");
    wait_one_a: assert property (s_req |=> !avs_waitrequest)
        else $error("bus answer not after one wait state");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    unmapped_zero_a: assert property (!avs_waitrequest && avs_read && avs_address > 5'h10
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : prs_sequencer_checker

/* File: power_up_reset_sequencer_tb.sv */
// Self-checking bench for the power-up reset sequencer
module power_up_reset_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] TICKS = 16'h0004;
    localparam int RC_DIV = 8;
    logic clock, rst_n, power_on_pulse, brownout_below, master_clear_pin_n, rc_tick, osc_tick;
    logic sleep_wake, brownout_enable_cfg, powerup_timer_enable_n, avs_read, avs_write;
    logic avs_waitrequest, chip_reset, clock_hold, irq;
    logic [1:0] osc_mode;
    logic [4:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, d;
    int errors = 0;
    int n_compared = 0;
    int n;
    prs_sequencer #(.POWERUP_TIMER_TICKS(TICKS)) dut (.clock(clock), .rst_n(rst_n),
        .power_on_pulse(power_on_pulse), .brownout_below(brownout_below),
        .master_clear_pin_n(master_clear_pin_n), .rc_tick(rc_tick), .osc_tick(osc_tick),
        .sleep_wake(sleep_wake), .brownout_enable_cfg(brownout_enable_cfg),
        .powerup_timer_enable_n(powerup_timer_enable_n), .osc_mode(osc_mode),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .chip_reset(chip_reset), .clock_hold(clock_hold), .irq(irq));
    prs_sup_model #(.RC_DIV(RC_DIV)) model (.clock(clock), .rc_tick(rc_tick), .osc_tick(osc_tick));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cycles(input int k);
        repeat (k) @(posedge clock);
    endtask : cycles
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 40) begin
            check("bus timeout", 1, 0);
            tally_and_finish();
        end
    endtask : bus
    // One-cycle event pulse: wake-up when wake is set, power-on otherwise
    task automatic pulse(input logic wake);
        if (wake) begin
            sleep_wake <= 1'b1;
        end else begin
            power_on_pulse <= 1'b1;
        end
        @(posedge clock);
        {power_on_pulse, sleep_wake} <= 2'h0;
        @(posedge clock);
    endtask : pulse
    task automatic wait_rst();
        n = 0;
        while (chip_reset !== 1'b0 && n < 6000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 6000) begin
            check("release timeout", 1, 0);
            tally_and_finish();
        end
    endtask : wait_rst
    // Cycles from sequence start to release
    function automatic logic in_range(int k, logic powerup_timer, logic osc_startup_timer);
        int t;
        t = powerup_timer ? int'(TICKS) * RC_DIV : 0;
        if (osc_startup_timer) t += 2 * prs_pkg::OST_CYCLES;
        return k >= t - RC_DIV && k <= t + RC_DIV + 8;
    endfunction : in_range
    initial begin
        rst_n = 1'b0;
        {power_on_pulse, brownout_below, sleep_wake, brownout_enable_cfg} = 4'h0;
        master_clear_pin_n = 1'b1;
        powerup_timer_enable_n = 1'b0;
        osc_mode = 2'h3;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        n = $urandom(82515);
        cycles(20);
        rst_n <= 1'b1;
        wait_rst();
        check("first release", in_range(n, 1, 0), 1);
        bus(0, prs_pkg::OFS_POWER_STATUS, 0);
        check("power-on flag", rd & 32'h2, 0);
        bus(0, prs_pkg::OFS_IRQ_ENABLE, 0);
        check("irq enable reset", rd, 0);
        bus(0, 5'h14, 0);
        check("unmapped read", rd, 0);
        for (int i = 0; i < 8; i++) begin
            osc_mode <= 2'(i);
            powerup_timer_enable_n <= i[2];
            brownout_enable_cfg <= 1'($urandom);
            @(posedge clock);
            pulse(1'b0);
            wait_rst();
            check("time-out", in_range(n, !powerup_timer_enable_n || brownout_enable_cfg,
                osc_mode != 2'h3), 1);
        end
        $display("Test time-out table done");
        osc_mode <= 2'h3;
        brownout_enable_cfg <= 1'b1;
        bus(1, prs_pkg::OFS_POWER_STATUS, 3);
        bus(0, prs_pkg::OFS_POWER_STATUS, 0);
        check("flags set", rd & 32'h3, 3);
        brownout_below <= 1'b1;
        cycles(50 + $urandom % 3000);
        brownout_below <= 1'b0;
        cycles(4);
        check("short dip", chip_reset, 0);
        brownout_below <= 1'b1;
        cycles(4100);
        check("brown-out reset", chip_reset, 1);
        brownout_below <= 1'b0;
        cycles(10);
        check("timer after brown-out", chip_reset, 1);
        brownout_below <= 1'b1;
        cycles(4100);
        brownout_below <= 1'b0;
        wait_rst();
        check("restarted interval", in_range(n, 1, 0), 1);
        bus(0, prs_pkg::OFS_POWER_STATUS, 0);
        check("flags after brown-out", rd & 32'h3, 2);
        brownout_enable_cfg <= 1'b0;
        brownout_below <= 1'b1;
        cycles(4500);
        brownout_below <= 1'b0;
        check("brown-out disabled", chip_reset, 0);
        $display("Test brown-out done");
        master_clear_pin_n <= 1'b0;
        pulse(1'b0);
        cycles(300);
        check("pin hold", chip_reset, 1);
        master_clear_pin_n <= 1'b1;
        cycles(3);
        check("pin release", chip_reset, 0);
        osc_mode <= 2'h0;
        cycles(2);
        pulse(1'b1);
        cycles(4);
        check("wake hold", {clock_hold, chip_reset}, 2'h2);
        cycles(2200);
        check("wake end", clock_hold, 0);
        osc_mode <= 2'h3;
        cycles(2);
        pulse(1'b1);
        cycles(4);
        check("wake in RC", clock_hold, 0);
        $display("Test pin and wake done");
        // Released, no counter busy, last reset was power-on
        bus(0, prs_pkg::OFS_SEQ_STATE, 0);
        check("sequence state", rd & 32'hF8, 32'h08);
        // Power-on, brown-out trip and release have all been seen
        bus(0, prs_pkg::OFS_IRQ_STATUS, 0);
        check("irq events", rd, 32'h7);
        bus(1, prs_pkg::OFS_IRQ_ENABLE, 1);
        cycles(2);
        check("irq raised", irq, 1);
        bus(1, prs_pkg::OFS_IRQ_ENABLE, 0);
        cycles(2);
        check("irq masked", irq, 0);
        bus(1, prs_pkg::OFS_IRQ_CLEAR, 7);
        bus(1, prs_pkg::OFS_IRQ_ENABLE, 7);
        cycles(2);
        check("irq cleared", irq, 0);
        bus(0, prs_pkg::OFS_IRQ_STATUS, 0);
        check("irq status", rd, 0);
        d = $urandom;
        bus(1, prs_pkg::OFS_IRQ_ENABLE, d);
        avs_byteenable <= 4'h0;
        bus(1, prs_pkg::OFS_IRQ_ENABLE, ~d);
        bus(0, prs_pkg::OFS_IRQ_ENABLE, 0);
        check("enable readback", rd, d & 32'h7);
        $display("Test registers done");
        tally_and_finish();
    end
endmodule : power_up_reset_sequencer_tb
bind prs_sequencer prs_sequencer_checker #(.POWERUP_TIMER_TICKS(POWERUP_TIMER_TICKS)) u_chk (.clock(clock),
    .rst_n(rst_n), .power_on_pulse(power_on_pulse), .brownout_below(brownout_below),
    .master_clear_pin_n(master_clear_pin_n), .brownout_enable_cfg(brownout_enable_cfg),
    .osc_mode(osc_mode), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chip_reset(chip_reset), .clock_hold(clock_hold));
